// *** pkg/cpu_core_consts.vh ***
// Purpose: Constants for the processor architectural state core
// Assumes: Included by the core design file
// Notes: Register bus offsets are byte addresses on AHB-Lite
`ifndef CPU_CORE_CONSTS_VH
`define CPU_CORE_CONSTS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FLAGS 8'h08
`define OFS_CSEG 8'h0C
`define OFS_SSEG 8'h10
`define OFS_DSEG 8'h14
`define OFS_ESEG 8'h18
`define OFS_FOFS 8'h1C
`define OFS_GPR 8'h20
`define OFS_ALU 8'h40
`define OFS_ALU_RES 8'h44
`define OFS_QUEUE 8'h48
`define OFS_ADDR 8'h4C
`define OFS_PHYS 8'h50
`define OFS_FETCH 8'h54
`define OFS_STRING 8'h58
`define OFS_PUSHIP 8'h5C
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FLAGS 16'hF000
`define RST_CSEG 16'hFFFF
`define RST_SEG 16'h0000
`define RST_FOFS 16'h0000
`define RST_CTRL 2'h1
// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define FB_CARRY 0
`define FB_PARITY 2
`define FB_AUX 4
`define FB_ZERO 6
`define FB_SIGN 7
`define FB_TRAP 8
`define FB_INTEN 9
`define FB_DIR 10
`define FB_OVF 11
`define FLAG_MASK 16'h0FD5
// ----------------------------------------
// Sizes and codes
// ----------------------------------------
`define SEG_SHIFT 4
`define QUEUE_DEPTH 3'h6
`define QCNT_W 3
`define ALU_ADD 3'h0
`define ALU_SUB 3'h1
`define ALU_AND 3'h2
`define ALU_OR 3'h3
`define ALU_XOR 3'h4
`define ALU_RCL 3'h5
`define SEL_CSEG 2'h0
`define SEL_SSEG 2'h1
`define SEL_DSEG 2'h2
`define SEL_ESEG 2'h3
`define CTRL_WIDE_BIT 0
`define CTRL_EXEC_BIT 1
`endif

// *** hw/cpu_core_arch_state.v ***
// Purpose: Architectural state, prefetch queue and address adder of core
// Assumes: AHB-Lite slave, single clock, memory answers fetch requests
// Notes: Execution requests and results are reached through registers
//
// Overview of operation
// - Fetch path sixteen bits wide or eight narrow
// - Execution takes opcode bytes, stalls when empty
// - Physical address is segment times sixteen plus offset
// - Fetching continues while execution is busy
// - Arithmetic unit works on bytes or words
// - Data registers split into bytes; pointers words
// - General registers are not reset
// - Reset clears data segments, code segment all ones
// - Reset clears fetch pointer, first fetch FFFF0
// - Pushed fetch pointer corrected to next instruction
// - Auxiliary carry from bit three into four
// - Carry out of top bit; rotate loads carry
// - Overflow on signed size excess; interrupt check
// - Sign copies top bit of result
// - Parity set for even count of ones
// - Zero set when result is zero
// - Direction flag selects decrement or increment
// - Interrupt enable gates only maskable requests
// - Trap flag requests interrupt after each instruction
// - Flag word resets to F000
// - Segments sixteen-byte aligned, at most 64K span
// - Fetches always use code segment and fetch pointer
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module cpu_core_arch_state (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST_N,
	// AHB-Lite slave
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output reg [31:0] HRDATA,
	output reg HREADYOUT,
	output reg HRESP,
	// Instruction fetch to memory
	output reg FETCH_REQ,
	output reg [19:0] FETCH_ADDR,
	output reg FETCH_WIDE,
	input wire FETCH_ACK,
	input wire [15:0] FETCH_DATA,
	// Interrupt sources and outcome
	input wire MASKABLE_IRQ,
	input wire NMI_REQ,
	output reg INT_TAKEN
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Segment plus offset, carry dropped
	function [19:0] phys_addr;
		input [15:0] seg;
		input [15:0] ofs;
		begin
			phys_addr = {seg, 4'h0} + {4'h0, ofs};
		end
	endfunction

	// Even parity of low byte
	function even_par;
		input [7:0] v;
		begin
			even_par = ~(^v);
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [15:0] gpr [0:7];
	reg [15:0] flags_ff, cseg_ff, sseg_ff, dseg_ff, eseg_ff, fofs_ff;
	reg [1:0] ctrl_ff;
	reg [7:0] queue [0:`QUEUE_DEPTH-1];
	reg [`QCNT_W-1:0] qcnt_ff, qrd_ff, qwr_ff;
	reg [7:0] opcode_ff;
	reg op_valid_ff, stall_ff, ovf_int_ff, trap_int_ff;
	reg [15:0] alu_res_ff, ptr_res_ff, push_ff;
	reg [19:0] phys_res_ff;
	reg [7:0] last_len_ff;
	reg sync1_ff, sync2_ff, nmi1_ff, nmi2_ff;
	// Bus phase capture
	reg wr_pend_ff;
	reg [7:0] wr_addr_ff;
	wire addr_phase = HSEL & HTRANS[1] & HREADY;
	wire [7:0] a = HADDR[7:0];
	// Bus write decode in data phase
	wire [7:0] wa = wr_addr_ff;
	wire [15:0] wd = HWDATA[15:0];
	wire wr_alu = wr_pend_ff & (wa == `OFS_ALU);
	wire wr_gpr = wr_pend_ff & (wa[7:5] == 3'h1) & (wa[1:0] == 2'h0);
	wire [2:0] gidx = wa[4:2];

	// ----------------------------------------
	// Arithmetic unit, operated by ALU register write
	// ----------------------------------------
	// Word HWDATA: [15:0] operand b, [18:16] op, [19] byte size,
	// [22:20] dest register, [23] high byte select
	wire [2:0] op = HWDATA[18:16];
	wire byte_op = HWDATA[19];
	wire [2:0] dst = HWDATA[22:20];
	wire hi_sel = HWDATA[23] & ~dst[2];
	reg [15:0] opa, res;
	reg [16:0] sum;
	reg cy, ac, ov, sg, zr;
	always @* begin
		// Operand select, byte halves only for data registers
		opa = hi_sel ? {8'h00, gpr[dst][15:8]} : gpr[dst];
		sum = 17'h00000;
		res = 16'h0000;
		case (op)
			`ALU_ADD: sum = {1'b0, opa} + {1'b0, wd};
			`ALU_SUB: sum = {1'b0, opa} - {1'b0, wd};
			`ALU_AND: sum = {1'b0, opa & wd};
			`ALU_OR: sum = {1'b0, opa | wd};
			`ALU_XOR: sum = {1'b0, opa ^ wd};
			// Rotate left by one bit through carry
			`ALU_RCL: sum = {opa, flags_ff[`FB_CARRY]};
			default: sum = 17'h00000;
		endcase
		res = sum[15:0];
		// Carry out of byte or word top bit
		if (op == `ALU_RCL)
			cy = byte_op ? opa[7] : opa[15];
		else if (op == `ALU_ADD || op == `ALU_SUB)
			cy = byte_op ? (res[8] ^ opa[8] ^ wd[8]) : sum[16];
		else
			cy = 1'b0;
		ac = res[4] ^ opa[4] ^ wd[4];
		if (op == `ALU_ADD)
			ov = byte_op ? (~(opa[7] ^ wd[7]) & (opa[7] ^ res[7]))
				: (~(opa[15] ^ wd[15]) & (opa[15] ^ res[15]));
		else if (op == `ALU_SUB)
			ov = byte_op ? ((opa[7] ^ wd[7]) & (opa[7] ^ res[7]))
				: ((opa[15] ^ wd[15]) & (opa[15] ^ res[15]));
		else
			ov = 1'b0;
		sg = byte_op ? res[7] : res[15];
		zr = byte_op ? (res[7:0] == 8'h00) : (res == 16'h0000);
	end

	// Flag word after arithmetic at fixed positions
	reg [15:0] nxt_flags;
	always @* begin
		nxt_flags = flags_ff;
		nxt_flags[`FB_CARRY] = cy;
		nxt_flags[`FB_PARITY] = even_par(res[7:0]);
		nxt_flags[`FB_AUX] = ac & (op == `ALU_ADD || op == `ALU_SUB);
		nxt_flags[`FB_ZERO] = zr;
		nxt_flags[`FB_SIGN] = sg;
		nxt_flags[`FB_OVF] = ov;
	end

	// ----------------------------------------
	// Prefetch queue and fetch engine
	// ----------------------------------------
	wire [`QCNT_W-1:0] room = `QUEUE_DEPTH - qcnt_ff;
	wire take = ctrl_ff[`CTRL_EXEC_BIT] & ~op_valid_ff & (qcnt_ff != 3'h0);
	wire take_clr = addr_phase & ~HWRITE & (a == `OFS_FETCH);
	wire fill2 = FETCH_WIDE & ~fofs_ff[0];
	wire [`QCNT_W-1:0] fill_n = FETCH_ACK ? (fill2 ? 3'h2 : 3'h1) : 3'h0;

	function [`QCNT_W-1:0] qinc;
		input [`QCNT_W-1:0] p;
		input [`QCNT_W-1:0] n;
		reg [`QCNT_W:0] t;
		begin
			t = {1'b0, p} + {1'b0, n};
			qinc = (t >= `QUEUE_DEPTH) ? t[`QCNT_W-1:0] - `QUEUE_DEPTH
				: t[`QCNT_W-1:0];
		end
	endfunction

	// Queue, fetch pointer and opcode handoff
	always @(posedge CLK_SYS) begin
		if (FETCH_ACK) begin
			queue[qwr_ff] <= fill2 ? FETCH_DATA[7:0]
				: (fofs_ff[0] ? FETCH_DATA[15:8] : FETCH_DATA[7:0]);
			if (fill2)
				queue[qinc(qwr_ff, 3'h1)] <= FETCH_DATA[15:8];
		end
	end

	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			qcnt_ff <= 3'h0;
			qrd_ff <= 3'h0;
			qwr_ff <= 3'h0;
			op_valid_ff <= 1'b0;
			opcode_ff <= 8'h00;
			stall_ff <= 1'b0;
			FETCH_REQ <= 1'b0;
			FETCH_ADDR <= 20'h00000;
			FETCH_WIDE <= 1'b0;
		end else begin
			qwr_ff <= qinc(qwr_ff, fill_n);
			qrd_ff <= take ? qinc(qrd_ff, 3'h1) : qrd_ff;
			qcnt_ff <= qcnt_ff + fill_n - {2'h0, take};
			if (take) begin
				opcode_ff <= queue[qrd_ff];
				op_valid_ff <= 1'b1;
			end else if (take_clr)
				op_valid_ff <= 1'b0;
			// Stall shown while wanting a byte and queue empty
			stall_ff <= ctrl_ff[`CTRL_EXEC_BIT] & ~op_valid_ff
				& (qcnt_ff == 3'h0);
			// Keep fetching while two or more bytes free, independent of execution
			FETCH_WIDE <= ctrl_ff[`CTRL_WIDE_BIT];
			FETCH_REQ <= (room >= 3'h2) & ~FETCH_ACK;
			FETCH_ADDR <= phys_addr(cseg_ff, fofs_ff);
		end
	end

	// ----------------------------------------
	// Interrupt recognition
	// ----------------------------------------
	// Two-stage sync of external request pins
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			nmi1_ff <= 1'b0;
			nmi2_ff <= 1'b0;
			INT_TAKEN <= 1'b0;
		end else begin
			sync1_ff <= MASKABLE_IRQ;
			sync2_ff <= sync1_ff;
			nmi1_ff <= NMI_REQ;
			nmi2_ff <= nmi1_ff;
			// Maskable only with enable, others always
			INT_TAKEN <= (sync2_ff & flags_ff[`FB_INTEN]) | nmi2_ff
				| ovf_int_ff | trap_int_ff;
		end
	end

	// ----------------------------------------
	// Architectural registers and bus writes
	// ----------------------------------------
	wire instr_done = take_clr & op_valid_ff;
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			flags_ff <= `RST_FLAGS;
			cseg_ff <= `RST_CSEG;
			sseg_ff <= `RST_SEG;
			dseg_ff <= `RST_SEG;
			eseg_ff <= `RST_SEG;
			fofs_ff <= `RST_FOFS;
			ctrl_ff <= `RST_CTRL;
			alu_res_ff <= 16'h0000;
			ptr_res_ff <= 16'h0000;
			push_ff <= 16'h0000;
			phys_res_ff <= 20'h00000;
			last_len_ff <= 8'h00;
			ovf_int_ff <= 1'b0;
			trap_int_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= addr_phase & HWRITE;
			wr_addr_ff <= a;
			// Fetch pointer tracks next byte to fetch
			if (FETCH_ACK)
				fofs_ff <= fofs_ff + {13'h0000, fill_n};
			// Trap after each completed instruction
			trap_int_ff <= instr_done & flags_ff[`FB_TRAP];
			ovf_int_ff <= 1'b0;
			if (instr_done)
				last_len_ff <= 8'h01;
			if (wr_alu) begin
				alu_res_ff <= res;
				flags_ff <= nxt_flags;
				if (~byte_op)
					gpr[dst] <= res;
				else if (hi_sel)
					gpr[dst][15:8] <= res[7:0];
				else
					gpr[dst][7:0] <= res[7:0];
			end
			if (wr_pend_ff)
				case (wa)
					`OFS_CTRL: ctrl_ff <= HWDATA[1:0];
					`OFS_FLAGS: flags_ff <= `RST_FLAGS
						| (wd & `FLAG_MASK);
					`OFS_CSEG: cseg_ff <= wd;
					`OFS_SSEG: sseg_ff <= wd;
					`OFS_DSEG: dseg_ff <= wd;
					`OFS_ESEG: eseg_ff <= wd;
					// Pointer reload only, queue contents are kept
					`OFS_FOFS: fofs_ff <= wd;
					// Offset with segment select in [17:16]
					`OFS_ADDR: phys_res_ff <= phys_addr(
						(HWDATA[17:16] == `SEL_CSEG) ? cseg_ff :
						(HWDATA[17:16] == `SEL_SSEG) ? sseg_ff :
						(HWDATA[17:16] == `SEL_DSEG) ? dseg_ff :
						eseg_ff, wd);
					// String step of index by direction flag
					`OFS_STRING: ptr_res_ff <= flags_ff[`FB_DIR]
						? wd - {14'h0000, HWDATA[16], ~HWDATA[16]}
						: wd + {14'h0000, HWDATA[16], ~HWDATA[16]};
					// Saved pointer minus queued and held bytes
					`OFS_PUSHIP: push_ff <= fofs_ff
						- {13'h0000, qcnt_ff}
						- {15'h0000, op_valid_ff};
					// Interrupt-on-overflow
					`OFS_ALU_RES: ovf_int_ff <= flags_ff[`FB_OVF];
					default: ;
				endcase
			if (wr_gpr)
				gpr[gidx] <= wd; // no reset value
		end
	end

	// ----------------------------------------
	// Read data and response
	// ----------------------------------------
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h00000000;
		if (a[7:5] == 3'h1)
			rdata = {16'h0000, gpr[a[4:2]]};
		else
			case (a)
				`OFS_CTRL: rdata = {30'h00000000, ctrl_ff};
				`OFS_STATUS: rdata = {24'h000000, stall_ff, op_valid_ff,
					last_len_ff[0], 2'h0, qcnt_ff};
				`OFS_FLAGS: rdata = {16'h0000, flags_ff};
				`OFS_CSEG: rdata = {16'h0000, cseg_ff};
				`OFS_SSEG: rdata = {16'h0000, sseg_ff};
				`OFS_DSEG: rdata = {16'h0000, dseg_ff};
				`OFS_ESEG: rdata = {16'h0000, eseg_ff};
				`OFS_FOFS: rdata = {16'h0000, fofs_ff};
				`OFS_ALU_RES: rdata = {16'h0000, alu_res_ff};
				`OFS_QUEUE: rdata = {29'h00000000, qcnt_ff};
				`OFS_PHYS: rdata = {12'h000, phys_res_ff};
				`OFS_FETCH: rdata = {23'h000000, op_valid_ff, opcode_ff};
				`OFS_STRING: rdata = {16'h0000, ptr_res_ff};
				`OFS_PUSHIP: rdata = {16'h0000, push_ff};
				default: rdata = 32'h00000000;
			endcase
	end

	// Zero-wait slave, OKAY always
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			if (addr_phase & ~HWRITE)
				HRDATA <= rdata;
		end
	end

endmodule

// *** verification/cpu_core_chk.sv ***
// Purpose: Port checks for the architectural state core
// Assumes: Sees only the top module ports
// Notes: Bound to every instance of the core
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module cpu_core_chk (
	// Clock and reset
	input wire CLK_SYS,
	input wire RST_N,
	// Register bus
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	input wire [31:0] HRDATA,
	input wire HREADYOUT,
	input wire HRESP,
	// Fetch link and interrupts
	input wire FETCH_REQ,
	input wire [19:0] FETCH_ADDR,
	input wire FETCH_WIDE,
	input wire FETCH_ACK,
	input wire NMI_REQ,
	input wire INT_TAKEN
);
	// ------
	// Helpers
	// ------
	reg ctrl_wr_ff;
	wire nxt_ctrl_wr;
	wire wlsb;
	assign wlsb = HWDATA[0];
	assign nxt_ctrl_wr = HSEL & HTRANS[1] & HWRITE
		& (HADDR[7:0] == `OFS_CTRL);
	// Data phase of a control word write
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			ctrl_wr_ff <= 1'b0;
		else if (HREADY)
			ctrl_wr_ff <= nxt_ctrl_wr;
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence s_wide_ack;
		FETCH_ACK && FETCH_WIDE && !FETCH_ADDR[0];
	endsequence
	sequence s_byte_ack;
		FETCH_ACK && !(FETCH_WIDE && !FETCH_ADDR[0]);
	endsequence
	// ------
	// Assertions
	// ------
	a_first_fetch: assert property ($rose(RST_N) |=>
		FETCH_REQ && FETCH_ADDR == 20'hFFFF0)
		else $error("first fetch address wrong");
	a_req_drops: assert property (FETCH_ACK |=> !FETCH_REQ)
		else $error("fetch request held after ack");
	a_req_holds: assert property (FETCH_REQ && !FETCH_ACK |=> FETCH_REQ)
		else $error("fetch request dropped without ack");
	a_addr_wide: assert property (s_wide_ack |-> ##2
		FETCH_ADDR == $past(FETCH_ADDR, 2) + 20'h2)
		else $error("wide fetch step wrong");
	a_addr_byte: assert property (s_byte_ack |-> ##2
		FETCH_ADDR == $past(FETCH_ADDR, 2) + 20'h1)
		else $error("byte fetch step wrong");
	a_nmi_taken: assert property ($rose(NMI_REQ) |-> ##[1:4] INT_TAKEN)
		else $error("nmi not taken");
	a_wide_follows: assert property (ctrl_wr_ff |-> ##2
		FETCH_WIDE == $past(wlsb, 2))
		else $error("fetch width not following control");
	a_rdata_holds: assert property (!(HSEL && HTRANS[1] && HREADY
		&& !HWRITE) |=> $stable(HRDATA))
		else $error("read data changed without read");
	a_okay_resp: assert property (HREADYOUT && !HRESP)
		else $error("bus response not ready okay");
endmodule
bind cpu_core_arch_state cpu_core_chk cpu_core_chk_inst (.CLK_SYS, .RST_N,
	.HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT,
	.HRESP, .FETCH_REQ, .FETCH_ADDR, .FETCH_WIDE, .FETCH_ACK, .NMI_REQ,
	.INT_TAKEN);

// *** verification/fetch_mem_model.sv ***
// Purpose: Memory answering instruction fetches
// Assumes: One ack per request, after a set lag
// Notes: Byte at address a reads a[7:0] xor 5A
`timescale 1ns/1ps
module fetch_mem_model (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Bench control
	input wire go,
	input wire [3:0] lag,
	// Fetch link
	input wire fetch_req,
	input wire [19:0] fetch_addr,
	output reg fetch_ack,
	output reg [15:0] fetch_data
);
	reg [3:0] wait_ff;
	// Ack only while requested; data lines toggle when idle
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fetch_ack <= 1'b0;
			wait_ff <= 4'h0;
			fetch_data <= 16'h0;
		end else if (fetch_ack) begin
			fetch_ack <= 1'b0;
			fetch_data <= ~fetch_data;
		end else if (go && fetch_req && wait_ff >= lag) begin
			fetch_ack <= 1'b1;
			wait_ff <= 4'h0;
			fetch_data <= {fetch_addr[7:0] | 8'h01,
				fetch_addr[7:0] & 8'hFE} ^ 16'h5A5A;
		end else begin
			wait_ff <= (go && fetch_req) ? wait_ff + 4'h1 : 4'h0;
			fetch_data <= ~fetch_data;
		end
	end
endmodule

// *** verification/cpu_core_arch_state_bench.sv ***
// Purpose: Self-checking bench for the architectural state core
// Assumes: Zero-wait register bus, memory model on fetch link
// Notes: All register traffic goes through one transfer task
`timescale 1ns/1ps
`include "cpu_core_consts.vh"
module cpu_core_arch_state_bench;
	reg clk_sys, rst_n, hsel, hwrite, irq, nmi, go;
	reg [31:0] haddr, hwdata, rd;
	reg [1:0] htrans;
	reg [3:0] lag;
	reg [15:0] ofs, ex;
	reg [19:0] pa, exp_pc;
	reg [15:0] seg [0:3];
	wire [31:0] hrdata;
	wire hreadyout, hresp, fetch_req, fetch_wide, fetch_ack, int_taken;
	wire [19:0] fetch_addr;
	wire [15:0] fetch_data;
	integer n_fail, n_compared, cyc, i;
	cpu_core_arch_state cpu_core_arch_state_inst (.CLK_SYS(clk_sys),
		.RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.FETCH_REQ(fetch_req), .FETCH_ADDR(fetch_addr),
		.FETCH_WIDE(fetch_wide), .FETCH_ACK(fetch_ack),
		.FETCH_DATA(fetch_data), .MASKABLE_IRQ(irq), .NMI_REQ(nmi),
		.INT_TAKEN(int_taken));
	fetch_mem_model fetch_mem_model_inst (.clk_sys, .rst_n, .go, .lag,
		.fetch_req, .fetch_addr, .fetch_ack, .fetch_data);
	// Clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			results;
		end
	end
	// ------
	// Tasks
	// ------
	task results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input [31:0] seen, input [31:0] exp, input [8*8:1] what);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		rd = hrdata;
	endtask
	task rchk(input [7:0] a, input [31:0] exp, input [8*8:1] what);
		xfer(1'b0, a, 32'h0);
		check(rd, exp, what);
	endtask
	task alu(input [2:0] r, input [15:0] v, input [31:0] cmd,
		input [15:0] res, input [15:0] fl);
		xfer(1'b1, `OFS_GPR + {3'h0, r, 2'h0}, {16'h0, v});
		xfer(1'b1, `OFS_ALU, cmd);
		rchk(`OFS_GPR + {3'h0, r, 2'h0}, {16'h0, res}, "alu");
		if (fl != 16'h0)
			rchk(`OFS_FLAGS, {16'h0, fl}, "flags");
	endtask
	task take;
		integer k;
		k = 0;
		xfer(1'b0, `OFS_FETCH, 32'h0);
		while (rd[8] !== 1'b1 && k < 20) begin
			k = k + 1;
			xfer(1'b0, `OFS_FETCH, 32'h0);
		end
		check(rd, {23'h0, 1'b1, exp_pc[7:0] ^ 8'h5A}, "opcode");
		exp_pc = exp_pc + 20'h1;
	endtask
	task int_chk(input exp);
		reg s;
		s = 1'b0;
		repeat (8) @(posedge clk_sys) if (int_taken === 1'b1) s = 1'b1;
		check({31'h0, s}, {31'h0, exp}, "int");
	endtask
	// ------
	// Main sequence
	// ------
	initial begin
		n_fail = 0;
		n_compared = 0;
		cyc = 0;
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		irq = 1'b0;
		nmi = 1'b0;
		go = 1'b0;
		lag = 4'h0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		check({12'h0, fetch_addr}, 32'hFFFF0, "fetch");
		for (i = 0; i < 6; i = i + 1)
			rchk(`OFS_FLAGS + {i[5:0], 2'b00}, i == 0 ? 32'hF000 :
				i == 1 ? 32'hFFFF : 32'h0, "reset");
		xfer(1'b1, `OFS_FLAGS, 32'hFFFFFFFF);
		rchk(`OFS_FLAGS, 32'hFFD5, "flags");
		xfer(1'b1, `OFS_FLAGS, 32'h0);
		xfer(1'b1, `OFS_DSEG, 32'hA5C3);
		xfer(1'b1, `OFS_ESEG, 32'hF000);
		seg[0] = 16'hFFFF;
		seg[1] = 16'h0;
		seg[2] = 16'hA5C3;
		seg[3] = 16'hF000;
		for (i = 0; i < 4; i = i + 1) begin
			ofs = 16'h1234 ^ {16{i[0]}};
			pa = {seg[i], 4'h0} + {4'h0, ofs};
			xfer(1'b1, `OFS_ADDR, {14'h0, i[1:0], ofs});
			rchk(`OFS_PHYS, {12'h0, pa}, "phys");
		end
		alu(3'h0, 16'h7FFF, 32'h1, 16'h8000, 16'hF894);
		alu(3'h1, 16'h1200, 32'h190001, 16'h12FF, 16'hF095);
		alu(3'h3, 16'h80FF, 32'hB80080, 16'h00FF, 16'hF845);
		for (i = 2; i < 6; i = i + 1) begin
			xfer(1'b1, `OFS_FLAGS, 32'h0);
			ex = i == 2 ? 16'h000F : i == 3 ? 16'h0FFF :
				i == 4 ? 16'h0FF0 : 16'h1E1E;
			alu(3'h4, 16'h0F0F, {9'h0, 3'h4, 1'b0, i[2:0], 16'h00FF}, ex,
				16'h0);
		end
		for (i = 0; i < 3; i = i + 1) begin
			xfer(1'b1, `OFS_FLAGS, {21'h0, i != 0, 10'h0});
			xfer(1'b1, `OFS_STRING, {15'h0, i != 2, 16'h1000});
			ex = i == 0 ? 16'h1002 : i == 1 ? 16'h0FFE : 16'h0FFF;
			rchk(`OFS_STRING, {16'h0, ex}, "string");
		end
		xfer(1'b1, `OFS_FLAGS, 32'h0);
		xfer(1'b1, `OFS_CTRL, 32'h3);
		go <= 1'b1;
		exp_pc = 20'hFFFF0;
		for (i = 0; i < 12; i = i + 1) begin
			if (i == 3)
				lag <= 4'h3;
			if (i == 6)
				xfer(1'b1, `OFS_CTRL, 32'h2);
			take;
		end
		go <= 1'b0;
		repeat (4) @(posedge clk_sys);
		xfer(1'b1, `OFS_PUSHIP, 32'h0);
		rchk(`OFS_PUSHIP, {16'h0, exp_pc[15:0] + 16'h10}, "push");
		xfer(1'b0, `OFS_STATUS, 32'h0);
		ex = {13'h0, rd[2:0]} + {15'h0, rd[6]};
		rchk(`OFS_QUEUE, {29'h0, rd[2:0]}, "queue");
		for (i = ex; i > 0; i = i - 1)
			take;
		xfer(1'b0, `OFS_FETCH, 32'h0);
		check({31'h0, rd[8]}, 32'h0, "empty");
		xfer(1'b0, `OFS_STATUS, 32'h0);
		check({31'h0, rd[7]}, 32'h1, "stall");
		irq <= 1'b1;
		int_chk(1'b0);
		xfer(1'b1, `OFS_FLAGS, 32'h100);
		go <= 1'b1;
		take;
		int_chk(1'b1);
		xfer(1'b1, `OFS_FLAGS, 32'h200);
		int_chk(1'b1);
		irq <= 1'b0;
		nmi <= 1'b1;
		xfer(1'b1, `OFS_FLAGS, 32'h0);
		int_chk(1'b1);
		nmi <= 1'b0;
		xfer(1'b1, `OFS_FLAGS, 32'h800);
		xfer(1'b1, `OFS_ALU_RES, 32'h0);
		int_chk(1'b1);
		results;
	end
endmodule
